/* File: verilog/ies_consts.svh */
// Purpose: named constants of the interrupt enable and source block
// Assumes: word index = byte address / 4 on the register bus
// Notes:   definitions only
`ifndef IES_CONSTS_SVH
`define IES_CONSTS_SVH

// ==========================================================
// register word indices
`define IES_IDX_INTERRUPT_ENABLE_0 8'hA8
`define IES_IDX_INTERRUPT_ENABLE_1 8'hA9
`define IES_IDX_INTERRUPT_ENABLE_2 8'hAA
`define IES_IDX_INTERRUPT_ENABLE_3 8'hAB
`define IES_IDX_SRC  8'hC0
`define IES_IDX_CTRL 8'hC1
`define IES_IDX_EXTF 8'hC2

// ==========================================================
// reset values and writable-bit masks
`define IES_RST_BYTE  8'h00
`define IES_INTERRUPT_ENABLE_0_MASK 8'hBF
`define IES_INTERRUPT_ENABLE_1_MASK 8'h3E
`define IES_INTERRUPT_ENABLE_2_MASK 8'h3C
`define IES_INTERRUPT_ENABLE_3_MASK 8'h30
`define IES_CTRL_MASK 8'h0F
`define IES_EXTF_MASK 8'h1F
`define IES_KEEP_ALL  8'hFF

// ==========================================================
// field positions
`define IES_MASTER_BIT 7
`define IES_SRC_L24    7
`define IES_SRC_ADC    6
`define IES_SRC_WTMR   5
`define IES_SRC_AVS    4
`define IES_SRC_DVS    3
`define IES_SRC_PWTMR  2
`define IES_SRC_AHS    1
`define IES_SRC_DHS    0
`define IES_EXF_P0     0
`define IES_EXF_P1     1
`define IES_EXF_X0     2
`define IES_EXF_X1     3
`define IES_EXF_CC     4
`define IES_CTL_P0_EDGE 0
`define IES_CTL_P1_EDGE 1
`define IES_CTL_X0_RISE 2
`define IES_CTL_X1_RISE 3

// ==========================================================
// request slots toward the core
`define IES_SLOTS     24
`define IES_RSV_SLOTS 24'h3C3040
`define IES_SL_EXT0 0
`define IES_SL_T0   1
`define IES_SL_EXT1 2
`define IES_SL_T1   3
`define IES_SL_UART 4
`define IES_SL_ADC  5
`define IES_SL_X0   7
`define IES_SL_WDT  8
`define IES_SL_X1   9
`define IES_SL_AVS  10
`define IES_SL_DVS  11
`define IES_SL_PWM  14
`define IES_SL_CC   15
`define IES_SL_AHS  16
`define IES_SL_DHS  17
`define IES_SL_L24  22
`define IES_SL_ADCW 23

`endif

/* File: verilog/ies_pkg.sv */
// Purpose: state types of the interrupt enable and source block
// Assumes: ies_consts.svh supplies the numbers
// Notes:   types only
package ies_pkg;

  // ==========================================================
  // pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ies_sync_t;

  // ==========================================================
  // top-level state
  typedef struct packed {
    logic [7:0] interrupt_enable_0;
    logic [7:0] interrupt_enable_1;
    logic [7:0] interrupt_enable_2;
    logic [7:0] interrupt_enable_3;
    logic [7:0] src;
    logic [7:0] ctrl;
    logic [7:0] extf;
    logic [8:0] prev;
    logic [23:0] irq;
    logic ack;
    logic [7:0] dat;
  } ies_state_t;

endpackage

/* File: verilog/ies_pin_sync.sv */
// Purpose: two-flop synchroniser with edge detection for one pin
// Assumes: pin is asynchronous to clk_i
// Notes:   edges are one-cycle pulses; level_o is the second flop
`timescale 1ns/100ps
module ies_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  ies_pkg::ies_sync_t s_q;
  ies_pkg::ies_sync_t s_d;

  // ==========================================================
  // state update; s1 feeds only s2
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.s2;
  assign rise_o = s_q.s2 & ~s_q.s3;
  assign fall_o = ~s_q.s2 & s_q.s3;

endmodule

/* File: verilog/ies_top.sv */
// Purpose: interrupt source collection and enable gating
// Assumes: classic Wishbone slave, 8-bit registers in lane 0
// Notes:   one registered request line per slot toward the core
`timescale 1ns/100ps
`include "ies_consts.svh"
module ies_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_pin_zero_i,
  input wire logic ext_irq_pin_one_i,
  input wire logic extra_ext_irq_zero_i,
  input wire logic extra_ext_irq_one_i,
  input wire logic global_irq_block_i,
  input wire logic timer_zero_overflow_flag_i,
  input wire logic timer_one_overflow_flag_i,
  input wire logic timer_zero_mode3_i,
  input wire logic timer_zero_high_count_ovf_i,
  input wire logic serial_port_irq_i,
  input wire logic converter_done_i,
  input wire logic converter_wakeup_irq_i,
  input wire logic line_twentyfour_irq_i,
  input wire logic watchdog_timer_ovf_i,
  input wire logic pwm_timer_ovf_i,
  input wire logic acq_vsync_irq_i,
  input wire logic acq_hsync_irq_i,
  input wire logic display_vsync_irq_i,
  input wire logic display_hsync_irq_i,
  input wire logic channel_change_irq_i,
  output logic [23:0] irq_req_o
);

  ies_pkg::ies_state_t s_q;
  ies_pkg::ies_state_t s_d;

  // ==========================================================
  // pin synchronisers
  logic p0_lvl, p0_fall, p1_lvl, p1_fall;
  logic x0_rise, x0_fall, x1_rise, x1_fall, blk_lvl;

  ies_pin_sync u_p0 (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(ext_irq_pin_zero_i),
    .level_o(p0_lvl), .rise_o(), .fall_o(p0_fall)
  );
  ies_pin_sync u_p1 (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(ext_irq_pin_one_i),
    .level_o(p1_lvl), .rise_o(), .fall_o(p1_fall)
  );
  ies_pin_sync u_x0 (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(extra_ext_irq_zero_i),
    .level_o(), .rise_o(x0_rise), .fall_o(x0_fall)
  );
  ies_pin_sync u_x1 (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(extra_ext_irq_one_i),
    .level_o(), .rise_o(x1_rise), .fall_o(x1_fall)
  );
  ies_pin_sync u_blk (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(global_irq_block_i),
    .level_o(blk_lvl), .rise_o(), .fall_o()
  );

  // ==========================================================
  // bus decode
  logic hit, wr;
  logic [7:0] idx;
  logic [7:0] wdat;

  assign hit = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = hit & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wdat = wb_dat_i[7:0];

  // ==========================================================
  // source vectors
  logic [8:0] lines;
  logic [8:0] rises;
  logic [23:0] pend;
  logic [23:0] en;
  logic [7:0] src_keep;
  logic [7:0] extf_keep;
  logic [7:0] extf_set;

  always_comb begin
    lines = {channel_change_irq_i, line_twentyfour_irq_i,
      converter_done_i, watchdog_timer_ovf_i, acq_vsync_irq_i,
      display_vsync_irq_i, pwm_timer_ovf_i, acq_hsync_irq_i,
      display_hsync_irq_i};
    // flags catch the rising edge so a long request line sets once
    rises = lines & ~s_q.prev;
    // software writes 0 to clear, 1 leaves a flag alone
    src_keep = `IES_KEEP_ALL;
    extf_keep = `IES_KEEP_ALL;
    if (wr && idx == `IES_IDX_SRC) begin
      src_keep = wdat;
    end
    if (wr && idx == `IES_IDX_EXTF) begin
      extf_keep = wdat;
    end
    extf_set = '0;
    // pins 0 and 1 are active low; edge mode latches the falling edge
    extf_set[`IES_EXF_P0] = s_q.ctrl[`IES_CTL_P0_EDGE] & p0_fall;
    extf_set[`IES_EXF_P1] = s_q.ctrl[`IES_CTL_P1_EDGE] & p1_fall;
    extf_set[`IES_EXF_X0] = s_q.ctrl[`IES_CTL_X0_RISE] ? x0_rise
      : x0_fall;
    extf_set[`IES_EXF_X1] = s_q.ctrl[`IES_CTL_X1_RISE] ? x1_rise
      : x1_fall;
    extf_set[`IES_EXF_CC] = rises[8];

    pend = '0;
    pend[`IES_SL_EXT0] = s_q.ctrl[`IES_CTL_P0_EDGE]
      ? s_q.extf[`IES_EXF_P0] : ~p0_lvl;
    pend[`IES_SL_EXT1] = s_q.ctrl[`IES_CTL_P1_EDGE]
      ? s_q.extf[`IES_EXF_P1] : ~p1_lvl;
    pend[`IES_SL_T0] = timer_zero_overflow_flag_i;
    pend[`IES_SL_T1] = timer_zero_mode3_i
      ? timer_zero_high_count_ovf_i
      : timer_one_overflow_flag_i;
    pend[`IES_SL_UART] = serial_port_irq_i;
    pend[`IES_SL_ADCW] = converter_wakeup_irq_i;
    pend[`IES_SL_ADC] = s_q.src[`IES_SRC_ADC];
    pend[`IES_SL_X0] = s_q.extf[`IES_EXF_X0];
    pend[`IES_SL_X1] = s_q.extf[`IES_EXF_X1];
    pend[`IES_SL_CC] = s_q.extf[`IES_EXF_CC];
    pend[`IES_SL_WDT] = s_q.src[`IES_SRC_WTMR];
    pend[`IES_SL_AVS] = s_q.src[`IES_SRC_AVS];
    pend[`IES_SL_DVS] = s_q.src[`IES_SRC_DVS];
    pend[`IES_SL_PWM] = s_q.src[`IES_SRC_PWTMR];
    pend[`IES_SL_AHS] = s_q.src[`IES_SRC_AHS];
    pend[`IES_SL_DHS] = s_q.src[`IES_SRC_DHS];
    pend[`IES_SL_L24] = s_q.src[`IES_SRC_L24];
    // six enable bits per register map straight onto slots
    en = {s_q.interrupt_enable_3[5:0], s_q.interrupt_enable_2[5:0], s_q.interrupt_enable_1[5:0],
      s_q.interrupt_enable_0[5:0]};
  end

  // ==========================================================
  // state update
  always_comb begin
    s_d = s_q;
    s_d.prev = lines;
    s_d.ack = hit;
    // set wins over a clear in the same cycle
    s_d.src = (s_q.src & src_keep) | rises[7:0];
    s_d.extf = ((s_q.extf & extf_keep) | extf_set) & `IES_EXTF_MASK;
    if (wr) begin
      case (idx)
        `IES_IDX_INTERRUPT_ENABLE_0: s_d.interrupt_enable_0 = wdat & `IES_INTERRUPT_ENABLE_0_MASK;
        `IES_IDX_INTERRUPT_ENABLE_1: s_d.interrupt_enable_1 = wdat & `IES_INTERRUPT_ENABLE_1_MASK;
        `IES_IDX_INTERRUPT_ENABLE_2: s_d.interrupt_enable_2 = wdat & `IES_INTERRUPT_ENABLE_2_MASK;
        `IES_IDX_INTERRUPT_ENABLE_3: s_d.interrupt_enable_3 = wdat & `IES_INTERRUPT_ENABLE_3_MASK;
        `IES_IDX_CTRL: s_d.ctrl = wdat & `IES_CTRL_MASK;
        default: s_d.interrupt_enable_0 = s_q.interrupt_enable_0;
      endcase
    end
    // unmapped reads answer with zero; masked bits read zero
    s_d.dat = `IES_RST_BYTE;
    if (hit && !wb_we_i) begin
      case (idx)
        `IES_IDX_INTERRUPT_ENABLE_0: s_d.dat = s_q.interrupt_enable_0;
        `IES_IDX_INTERRUPT_ENABLE_1: s_d.dat = s_q.interrupt_enable_1;
        `IES_IDX_INTERRUPT_ENABLE_2: s_d.dat = s_q.interrupt_enable_2;
        `IES_IDX_INTERRUPT_ENABLE_3: s_d.dat = s_q.interrupt_enable_3;
        `IES_IDX_SRC: s_d.dat = s_q.src;
        `IES_IDX_CTRL: s_d.dat = s_q.ctrl;
        `IES_IDX_EXTF: s_d.dat = s_q.extf;
        default: s_d.dat = `IES_RST_BYTE;
      endcase
    end
    // block input overrides master enable; reserved slots stay low
    if (s_q.interrupt_enable_0[`IES_MASTER_BIT] && !blk_lvl) begin
      s_d.irq = pend & en & ~`IES_RSV_SLOTS;
    end else begin
      s_d.irq = '0;
    end
  end

  // the core arbitrates the four nesting levels over these lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_req_o = s_q.irq;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.dat};

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic on_q;
  assign on_q = s_q.interrupt_enable_0[`IES_MASTER_BIT] & ~blk_lvl;

  sequence seq_adc_edge;
    !converter_done_i ##1 converter_done_i;
  endsequence

  sequence seq_adc_armed;
    on_q && s_q.interrupt_enable_0[`IES_SL_ADC];
  endsequence

  AST_MASTER_OFF: assert property (
    !s_q.interrupt_enable_0[`IES_MASTER_BIT] |=> irq_req_o == '0)
    else $error("request while master enable off");

  AST_BLOCK: assert property (
    blk_lvl |=> irq_req_o == '0)
    else $error("request while globally blocked");

  AST_RESERVED: assert property (
    (irq_req_o & `IES_RSV_SLOTS) == '0)
    else $error("reserved slot requested");

  AST_ADC_FLAG: assert property (
    seq_adc_edge |=> s_q.src[`IES_SRC_ADC])
    else $error("converter flag not set by edge");

  // software may clear the flag before it reaches the core
  AST_ADC_REQ: assert property (
    seq_adc_edge ##1 seq_adc_armed
      ##1 (seq_adc_armed and s_q.src[`IES_SRC_ADC])
      |=> irq_req_o[`IES_SL_ADC])
    else $error("converter request missing");

  AST_NO_AUTOCLR: assert property (
    s_q.src[`IES_SRC_L24] && !(wr && idx == `IES_IDX_SRC)
      |=> s_q.src[`IES_SRC_L24])
    else $error("flag cleared without software");

  AST_T1_MODE3: assert property (
    on_q && s_q.interrupt_enable_0[`IES_SL_T1] && timer_zero_mode3_i
      && timer_zero_high_count_ovf_i |=> irq_req_o[`IES_SL_T1])
    else $error("mode 3 timer one request missing");

  AST_GATE: assert property (
    irq_req_o[`IES_SL_UART] |-> $past(s_q.interrupt_enable_0[`IES_SL_UART])
      && $past(serial_port_irq_i))
    else $error("request without enable or source");

  AST_READ_ZERO: assert property (
    wb_ack_o && $past(idx) == `IES_IDX_INTERRUPT_ENABLE_2 |-> wb_dat_o[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");

  AST_P0_LEVEL: assert property (
    on_q && s_q.interrupt_enable_0[`IES_SL_EXT0] && !p0_lvl
      && !s_q.ctrl[`IES_CTL_P0_EDGE] |=> irq_req_o[`IES_SL_EXT0])
    else $error("level pin request missing");

  AST_X0_EDGE: assert property (
    !s_q.ctrl[`IES_CTL_X0_RISE] && x0_fall |=> s_q.extf[`IES_EXF_X0])
    else $error("extra pin edge not caught");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  AST_ACK_ANSWER: assert property (
    hit |=> wb_ack_o)
    else $error("request not answered in one cycle");

  AST_DAT_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside an answer");

  AST_INTERRUPT_ENABLE_0_RSV: assert property (
    (s_q.interrupt_enable_0 & ~`IES_INTERRUPT_ENABLE_0_MASK) == '0)
    else $error("reserved bit set in enable 0");

  AST_INTERRUPT_ENABLE_1_RSV: assert property (
    (s_q.interrupt_enable_1 & ~`IES_INTERRUPT_ENABLE_1_MASK) == '0)
    else $error("reserved bit set in enable 1");

  AST_INTERRUPT_ENABLE_2_RSV: assert property (
    (s_q.interrupt_enable_2 & ~`IES_INTERRUPT_ENABLE_2_MASK) == '0)
    else $error("reserved bit set in enable 2");

  AST_INTERRUPT_ENABLE_3_RSV: assert property (
    (s_q.interrupt_enable_3 & ~`IES_INTERRUPT_ENABLE_3_MASK) == '0)
    else $error("reserved bit set in enable 3");

  // a clear in the same cycle must lose against the edge
  AST_SRC_SET_WINS: assert property (
    rises[`IES_SRC_DVS] |=> s_q.src[`IES_SRC_DVS])
    else $error("display flag lost its edge");

  AST_X1_RISE: assert property (
    s_q.ctrl[`IES_CTL_X1_RISE] && x1_rise |=> s_q.extf[`IES_EXF_X1])
    else $error("extra pin rising edge not caught");

  AST_P0_EDGE: assert property (
    s_q.ctrl[`IES_CTL_P0_EDGE] && p0_fall |=> s_q.extf[`IES_EXF_P0])
    else $error("pin zero edge not caught");

  AST_UART_LEVEL: assert property (
    on_q && en[`IES_SL_UART] && serial_port_irq_i
      |=> irq_req_o[`IES_SL_UART])
    else $error("serial level request missing");

  AST_WAKE_LEVEL: assert property (
    on_q && en[`IES_SL_ADCW] && converter_wakeup_irq_i
      |=> irq_req_o[`IES_SL_ADCW])
    else $error("wake-up request missing");

endmodule

/* File: tb/ies_core_model.sv */
// Purpose: stand-in for the core that takes the request lines
// Assumes: requests are registered levels on clk_i
// Notes:   latches any request seen on a reserved slot
`timescale 1ns/100ps
`include "ies_consts.svh"
module ies_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [23:0] irq_req_i,
  output logic rsv_seen_o
);
  // ==========================================================
  // reserved slot watch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsv_seen_o <= 1'h0;
    end else if ((irq_req_i & `IES_RSV_SLOTS) != 24'h000000) begin
      rsv_seen_o <= 1'h1;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the enable and source block
// Assumes: classic Wishbone, one register per word in lane 0
// Notes:   each scenario is one task; waits are bounded
`timescale 1ns/100ps
`include "ies_consts.svh"
module testbench;
  // ==========================================================
  // stimulus and observation
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [23:0] irq_req_o;
  logic rsv_seen;
  logic pin0 = 1'h1, pin1 = 1'h1, xt0 = 1'h0, xt1 = 1'h1, blk = 1'h0;
  logic tf0 = 1'h0, tf1 = 1'h0, m3 = 1'h0, th0 = 1'h0;
  logic uart = 1'h0, wake = 1'h0;
  logic adc = 1'h0, l24 = 1'h0, wdt = 1'h0, pwm = 1'h0, avs = 1'h0;
  logic ahs = 1'h0, dvs = 1'h0, dhs = 1'h0, chg = 1'h0;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  ies_top ies_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_irq_pin_zero_i(pin0),
    .ext_irq_pin_one_i(pin1), .extra_ext_irq_zero_i(xt0),
    .extra_ext_irq_one_i(xt1), .global_irq_block_i(blk),
    .timer_zero_overflow_flag_i(tf0), .timer_one_overflow_flag_i(tf1),
    .timer_zero_mode3_i(m3), .timer_zero_high_count_ovf_i(th0),
    .serial_port_irq_i(uart), .converter_done_i(adc),
    .converter_wakeup_irq_i(wake), .line_twentyfour_irq_i(l24),
    .watchdog_timer_ovf_i(wdt), .pwm_timer_ovf_i(pwm),
    .acq_vsync_irq_i(avs), .acq_hsync_irq_i(ahs),
    .display_vsync_irq_i(dvs), .display_hsync_irq_i(dhs),
    .channel_change_irq_i(chg), .irq_req_o(irq_req_o)
  );

  ies_core_model ies_core_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
    .rsv_seen_o(rsv_seen)
  );

  always #2 clk_i = ~clk_i;

  // ==========================================================
  // shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a hung run is cut short well after the two hundred or so cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, wd};
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, idx, d, x);
  endtask

  task automatic rchk(input string what, input logic [7:0] idx,
                      input logic [7:0] exp);
    logic [7:0] x;
    bus(1'h0, idx, 8'h00, x);
    chk(what, {24'h000000, x}, {24'h000000, exp});
  endtask

  // pins pass a synchroniser, so allow a few cycles to settle
  task automatic ichk(input string what, input logic [23:0] exp);
    repeat (6) @(posedge clk_i);
    chk(what, {8'h00, irq_req_o}, {8'h00, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rchk("enable0", `IES_IDX_INTERRUPT_ENABLE_0, 8'h00);
    rchk("enable1", `IES_IDX_INTERRUPT_ENABLE_1, 8'h00);
    rchk("enable2", `IES_IDX_INTERRUPT_ENABLE_2, 8'h00);
    rchk("enable3", `IES_IDX_INTERRUPT_ENABLE_3, 8'h00);
    chk("requests", {8'h00, irq_req_o}, 32'h00000000);
    $display("done: reset values");
  endtask

  task automatic t_regs;
    wr(`IES_IDX_INTERRUPT_ENABLE_0, 8'hFF);
    wr(`IES_IDX_INTERRUPT_ENABLE_1, 8'hFF);
    wr(`IES_IDX_INTERRUPT_ENABLE_2, 8'hFF);
    wr(`IES_IDX_INTERRUPT_ENABLE_3, 8'hFF);
    wr(8'h10, 8'hFF);
    rchk("enable0", `IES_IDX_INTERRUPT_ENABLE_0, 8'hBF);
    rchk("enable1", `IES_IDX_INTERRUPT_ENABLE_1, 8'h3E);
    rchk("enable2", `IES_IDX_INTERRUPT_ENABLE_2, 8'h3C);
    rchk("enable3", `IES_IDX_INTERRUPT_ENABLE_3, 8'h30);
    rchk("unmapped", 8'h10, 8'h00);
    $display("done: register access");
  endtask

  task automatic t_levels;
    @(posedge clk_i);
    uart <= 1'h1;
    tf0 <= 1'h1;
    wake <= 1'h1;
    ichk("levels", 24'h800012);
    wr(`IES_IDX_INTERRUPT_ENABLE_0, 8'h3F);
    ichk("master off", 24'h000000);
    wr(`IES_IDX_INTERRUPT_ENABLE_0, 8'hBF);
    blk <= 1'h1;
    ichk("blocked", 24'h000000);
    blk <= 1'h0;
    wr(`IES_IDX_INTERRUPT_ENABLE_0, 8'h80);
    ichk("single enable", 24'h800000);
    wr(`IES_IDX_INTERRUPT_ENABLE_0, 8'hBF);
    {uart, tf0, wake, m3, th0} <= 5'h03;
    ichk("mode3 high count", 24'h000008);
    m3 <= 1'h0;
    ichk("high count ignored", 24'h000000);
    {th0, tf1} <= 2'h1;
    ichk("timer one", 24'h000008);
    tf1 <= 1'h0;
    $display("done: level gating");
  endtask

  task automatic t_edges;
    @(posedge clk_i);
    {adc, l24, wdt, pwm, avs, ahs, dvs, dhs, chg} <= 9'h1FF;
    @(posedge clk_i);
    {adc, l24, wdt, pwm, avs, ahs, dvs, dhs, chg} <= 9'h000;
    ichk("edge requests", 24'h43CD20);
    rchk("source flags", `IES_IDX_SRC, 8'hFF);
    rchk("ext flags", `IES_IDX_EXTF, 8'h10);
    ichk("flags held", 24'h43CD20);
    wr(`IES_IDX_SRC, 8'h00);
    wr(`IES_IDX_EXTF, 8'h00);
    rchk("source cleared", `IES_IDX_SRC, 8'h00);
    ichk("cleared", 24'h000000);
    $display("done: edge sources");
  endtask

  task automatic t_pins;
    @(posedge clk_i);
    pin0 <= 1'h0;
    ichk("pin zero level", 24'h000001);
    pin0 <= 1'h1;
    wr(`IES_IDX_CTRL, 8'h06);
    pin1 <= 1'h0;
    repeat (6) @(posedge clk_i);
    pin1 <= 1'h1;
    xt0 <= 1'h1;
    xt1 <= 1'h0;
    ichk("pin edges", 24'h000284);
    rchk("pin flags", `IES_IDX_EXTF, 8'h0E);
    xt0 <= 1'h0;
    wr(`IES_IDX_EXTF, 8'h00);
    ichk("wrong edge", 24'h000000);
    wr(`IES_IDX_CTRL, 8'h09);
    pin0 <= 1'h0;
    xt1 <= 1'h1;
    ichk("edge modes", 24'h000201);
    pin0 <= 1'h1;
    rchk("edge mode flags", `IES_IDX_EXTF, 8'h09);
    wr(`IES_IDX_EXTF, 8'h00);
    ichk("edge flags cleared", 24'h000000);
    $display("done: external pins");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_regs();
    t_levels();
    t_edges();
    t_pins();
    chk("reserved slots", {31'h0, rsv_seen}, 32'h0);
    finish_test();
  end
endmodule
